// >>> spi_pin_pkg.sv
// How it works
// - Output bit launched after serial clock falls
// - Input bit captured on serial clock rise
// - Deselected means serial output floats
// - Deselect gives standby unless cycle busy
// - Select low gives active power, ready
// - No command before first select fall
// - Pause suspends transfer, keeps selection
// - Paused: output floats, input and clock ignored
// - Protect low freezes block-protect level bits
package spi_pin_pkg;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned CNT_W = 3;
	localparam logic [2:0] PROTECT_RST = 3'h0;

	typedef enum logic [1:0]
	{
		PWR_STANDBY = 2'h0,
		PWR_ACTIVE = 2'h1,
		PWR_BUSY = 2'h3
	} pwr_mode_t;

	typedef struct packed
	{
		logic sck;
		logic cs_n;
		logic sin;
		logic pause_n;
		logic wp_n;
	} pin_in_t;
endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import spi_pin_pkg::*;
#(
	parameter int unsigned WIDTH = 5
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] rst_val,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			meta_ff <= rst_val;
			sync_ff <= rst_val;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule
`default_nettype wire

// >>> serial_flash_pin_interface.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface
	import spi_pin_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic pause_n,
	input wire logic wp_n,
	input wire logic cycle_busy,
	input wire logic tx_bit,
	input wire logic [2:0] protect_level_req,
	input wire logic protect_level_wr,
	output logic serial_out,
	output logic serial_out_oe,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic tx_bit_req,
	output logic cmd_abort,
	output logic cmd_armed,
	output logic paused,
	output logic active_power,
	output logic [2:0] protect_level
);
	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	pin_in_t pins_raw;
	pin_in_t pins;
	pin_in_t pins_rst;

	assign pins_raw = '{sck: sck, cs_n: cs_n, sin: serial_in, pause_n: pause_n, wp_n: wp_n};
	assign pins_rst = '{sck: 1'b0, cs_n: 1'b1, sin: 1'b0, pause_n: 1'b1, wp_n: 1'b1};

	pin_sync #(.WIDTH($bits(pin_in_t))) u_sync
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(pins_raw),
		.rst_val(pins_rst),
		.sync_out(pins)
	);

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic sck_d_ff;
	logic cs_n_d_ff;
	logic paused_ff;
	logic armed_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [7:0] shift_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sck_d_ff <= 1'b0;
			cs_n_d_ff <= 1'b1;
		end
		else
		begin
			sck_d_ff <= pins.sck;
			cs_n_d_ff <= pins.cs_n;
		end
	end

	// ----------------------------------------
	// Synchroniser settle
	// ----------------------------------------
	// Edges count only once sync and delay flops hold real pin levels
	logic [SYNC_STAGES:0] settle_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			settle_ff <= '0;
		end
		else
		begin
			settle_ff <= {settle_ff[SYNC_STAGES-1:0], 1'b1};
		end
	end

	wire settled = settle_ff[SYNC_STAGES];

	wire selected = !pins.cs_n;
	wire cs_fall = cs_n_d_ff && !pins.cs_n;
	wire cs_rise = !cs_n_d_ff && pins.cs_n;
	wire sck_rise = !sck_d_ff && pins.sck;
	wire sck_fall = sck_d_ff && !pins.sck;
	wire sck_low = !pins.sck && !sck_d_ff;

	// ----------------------------------------
	// Link state
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		LNK_OFF = 2'h0,
		LNK_ON = 2'h1,
		LNK_HOLD = 2'h3
	} link_state_t;

	link_state_t state_ff;
	link_state_t nxt_state;

	// Pause state moves only while clock is low; leaves on deselect
	wire pause_enter = !pins.pause_n && sck_low;
	wire pause_exit = pins.pause_n && sck_low;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			LNK_OFF:
			begin
				if (selected)
				begin
					nxt_state = LNK_ON;
				end
			end
			LNK_ON:
			begin
				if (!selected)
				begin
					nxt_state = LNK_OFF;
				end
				else if (pause_enter)
				begin
					nxt_state = LNK_HOLD;
				end
			end
			LNK_HOLD:
			begin
				if (!selected)
				begin
					nxt_state = LNK_OFF;
				end
				else if (pause_exit)
				begin
					nxt_state = LNK_ON;
				end
			end
			default:
			begin
				nxt_state = LNK_OFF;
			end
		endcase
	end

	wire run = (state_ff == LNK_ON) && armed_ff;

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	wire take_bit = run && sck_rise;
	wire byte_done = take_bit && (cnt_ff == CNT_W'(BYTE_BITS - 1));
	wire [7:0] nxt_shift = {shift_ff[6:0], pins.sin};
	wire [CNT_W-1:0] nxt_cnt = cs_rise ? '0 : (take_bit ? cnt_ff + 1'b1 : cnt_ff);
	wire nxt_armed = armed_ff || (cs_fall && settled);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_ff <= LNK_OFF;
			paused_ff <= 1'b0;
			armed_ff <= 1'b0;
			cnt_ff <= '0;
			shift_ff <= 8'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			paused_ff <= (nxt_state == LNK_HOLD);
			armed_ff <= nxt_armed;
			cnt_ff <= nxt_cnt;
			shift_ff <= take_bit ? nxt_shift : shift_ff;
		end
	end

	// ----------------------------------------
	// Transmit path and power mode
	// ----------------------------------------
	wire launch = run && sck_fall;
	wire nxt_oe = (nxt_state == LNK_ON);
	pwr_mode_t nxt_pwr;
	assign nxt_pwr = selected ? PWR_ACTIVE : (cycle_busy ? PWR_BUSY : PWR_STANDBY);
	// Protect level frozen while protect input is low
	wire prot_load = protect_level_wr && pins.wp_n;

	logic serial_out_ff;
	logic oe_ff;
	logic [7:0] rx_byte_ff;
	logic rx_valid_ff;
	logic tx_req_ff;
	logic abort_ff;
	logic [2:0] protect_ff;
	logic active_ff;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			serial_out_ff <= 1'b0;
			oe_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			tx_req_ff <= 1'b0;
			abort_ff <= 1'b0;
			protect_ff <= PROTECT_RST;
			active_ff <= 1'b0;
		end
		else
		begin
			serial_out_ff <= launch ? tx_bit : serial_out_ff;
			oe_ff <= nxt_oe;
			rx_byte_ff <= byte_done ? nxt_shift : rx_byte_ff;
			rx_valid_ff <= byte_done;
			tx_req_ff <= launch;
			abort_ff <= cs_rise && (cnt_ff != '0);
			protect_ff <= prot_load ? protect_level_req : protect_ff;
			active_ff <= (nxt_pwr != PWR_STANDBY);
		end
	end

	assign serial_out = serial_out_ff;
	assign serial_out_oe = oe_ff;
	assign rx_byte = rx_byte_ff;
	assign rx_byte_valid = rx_valid_ff;
	assign tx_bit_req = tx_req_ff;
	assign cmd_abort = abort_ff;
	assign cmd_armed = armed_ff;
	assign paused = paused_ff;
	assign active_power = active_ff;
	assign protect_level = protect_ff;
endmodule
`default_nettype wire

// >>> flash_pin_properties.sv
`timescale 1ns/1ps
`default_nettype none
module flash_pin_properties
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic cycle_busy,
	input wire logic tx_bit_req,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic rx_byte_valid,
	input wire logic cmd_abort,
	input wire logic cmd_armed,
	input wire logic paused,
	input wire logic active_power,
	input wire logic [2:0] protect_level
);
	// ----
	// Checks
	// ----
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_FLOAT: assert property (cs_n [*8] |-> !serial_out_oe) else $error("oe");
	AST_PFLOAT: assert property (paused [*2] |-> !serial_out_oe) else $error("poe");
	AST_ARM: assert property (rx_byte_valid |-> cmd_armed) else $error("arm");
	AST_WP: assert property (!wp_n [*4] |=> $stable(protect_level)) else $error("wp");
	AST_BUSY: assert property (cycle_busy [*2] |-> active_power) else $error("busy");
	AST_STBY: assert property ((cs_n && !cycle_busy) [*8] |-> !active_power) else $error("stby");
	AST_SEL: assert property (!cs_n [*8] |-> active_power) else $error("act");
	AST_LAUNCH: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
		|-> tx_bit_req) else $error("so");
	AST_ABORT: assert property (cmd_abort |-> !rx_byte_valid && cs_n && $past(cs_n, 3)) else $error("ab");
	cover property (rx_byte_valid);
	cover property (cmd_abort);
	cover property (paused);
endmodule
`default_nettype wire

// >>> spi_master.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master
(
	input wire logic clk,
	input wire logic so,
	input wire logic so_oe,
	output logic sck,
	output logic cs_n,
	output logic din,
	output logic pause_n
);
	logic [7:0] miso = 8'h00;
	initial {sck, cs_n, din, pause_n} = 4'h5;
	task automatic hp;
		repeat (5) @(posedge clk);
		#5;
	endtask
	task automatic sel(input logic v);
		hp();
		cs_n = v;
		din = ~din;
		hp();
	endtask
	task automatic shift(input logic [7:0] d, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			din = d[i];
			hp();
			miso = {miso[6:0], so_oe ? so : ~so};
			sck = 1;
			hp();
			sck = 0;
		end
		din = ~din;
	endtask
	task automatic hold(input logic v);
		hp();
		pause_n = v;
		hp();
	endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk = 0, rst = 1, cycle_busy = 0, tx_bit = 1, wp_n = 1, protect_level_wr = 0;
	logic sck, cs_n, serial_in, pause_n, serial_out, serial_out_oe, rx_byte_valid, tx_bit_req;
	logic cmd_abort, cmd_armed, paused, active_power;
	logic [2:0] protect_level_req = 3'h5, protect_level;
	logic [7:0] rx_byte, got = 8'h00;
	int miscompares = 0, cmp_count = 0, nab = 0;
	initial forever #25 sys_clk = ~sys_clk;
	spi_master m
	(
		.clk(sys_clk),
		.so(serial_out),
		.so_oe(serial_out_oe),
		.sck(sck),
		.cs_n(cs_n),
		.din(serial_in),
		.pause_n(pause_n)
	);
	serial_flash_pin_interface DUT
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.sck(sck),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.pause_n(pause_n),
		.wp_n(wp_n),
		.cycle_busy(cycle_busy),
		.tx_bit(tx_bit),
		.protect_level_req(protect_level_req),
		.protect_level_wr(protect_level_wr),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid),
		.tx_bit_req(tx_bit_req),
		.cmd_abort(cmd_abort),
		.cmd_armed(cmd_armed),
		.paused(paused),
		.active_power(active_power),
		.protect_level(protect_level)
	);
	always @(posedge sys_clk)
	begin
		if (rx_byte_valid === 1'b1) got <= rx_byte;
		if (tx_bit_req === 1'b1) tx_bit <= #5 ~tx_bit;
		if (cmd_abort === 1'b1) nab <= nab + 1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#5;
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		cmp_count++;
		if (a !== e)
		begin
			miscompares++;
			$display("BAD %0t %h %h", $time, a, e);
		end
	endtask
	task automatic wr(input logic w);
		wp_n = w;
		cyc(5);
		protect_level_wr = 1;
		cyc(1);
		protect_level_wr = 0;
		cyc(2);
	endtask
	task stop_test;
		$display("cmp %0d bad %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	// Select held low through reset: no falling edge seen yet
	task automatic test_arm;
		m.shift(8'hff, 8);
		chk(cmd_armed, 0);
		chk(got, 0);
		m.sel(1);
		m.sel(0);
		chk(cmd_armed, 1);
		$display("arm done");
	endtask
	// Bits launched alternate 1,0,..; first rise sees reset level
	task automatic test_rx;
		m.shift(8'ha5, 8);
		chk(got, 8'ha5);
		chk({serial_out_oe, active_power}, 2'h3);
		chk(m.miso, 8'h55);
		$display("rx done");
	endtask
	task automatic test_pause;
		m.shift(8'h3c, 4);
		m.hold(0);
		chk({paused, serial_out_oe}, 2'h2);
		m.shift(8'h00, 3);
		m.hold(1);
		m.shift(8'hc0, 4);
		chk(got, 8'h3c);
		$display("pause done");
	endtask
	task automatic test_abort;
		m.shift(8'h00, 3);
		m.sel(1);
		chk({nab[0], serial_out_oe, active_power}, 3'h4);
		cycle_busy = 1;
		cyc(3);
		chk(active_power, 1);
		cycle_busy = 0;
		cyc(5);
		chk(active_power, 0);
		m.sel(0);
		m.shift(8'h81, 8);
		chk(got, 8'h81);
		$display("abort done");
	endtask
	task automatic test_protect;
		wr(0);
		chk(protect_level, 0);
		wr(1);
		chk(protect_level, 5);
		$display("protect done");
	endtask
	initial
	begin
		m.sel(0);
		cyc(10);
		rst = 0;
		test_arm();
		test_rx();
		test_pause();
		test_abort();
		test_protect();
		stop_test;
	end
endmodule
bind serial_flash_pin_interface flash_pin_properties chk_i
(
	.sys_clk(sys_clk),
	.rst(rst),
	.cs_n(cs_n),
	.wp_n(wp_n),
	.cycle_busy(cycle_busy),
	.tx_bit_req(tx_bit_req),
	.serial_out(serial_out),
	.serial_out_oe(serial_out_oe),
	.rx_byte_valid(rx_byte_valid),
	.cmd_abort(cmd_abort),
	.cmd_armed(cmd_armed),
	.paused(paused),
	.active_power(active_power),
	.protect_level(protect_level)
);
`default_nettype wire
